/* File: rtl/mtb_pkg.sv */
package mtb_pkg;
	localparam int NCH     = 5;
	localparam int CW      = 16;
	localparam int NFL     = 3;
	localparam int NOUT    = 6;
	localparam int CH_BUF0 = 3;
	// per-channel word index; channel n occupies byte 0x20*n upward
	localparam logic [2:0] R_CTRL  = 3'h0;
	localparam logic [2:0] R_STAT  = 3'h1;
	localparam logic [2:0] R_CNT   = 3'h2;
	localparam logic [2:0] R_GRA   = 3'h3;
	localparam logic [2:0] R_GRB   = 3'h4;
	localparam logic [2:0] R_BRA   = 3'h5;
	localparam logic [2:0] R_BRB   = 3'h6;
	localparam logic [2:0] CH_LAST = 3'h4;
	// shared registers
	localparam logic [7:0] A_MODE   = 8'ha0;
	localparam logic [7:0] A_OUTEN  = 8'ha4;
	localparam logic [7:0] A_OUTCTL = 8'ha8;
	// channel control fields
	localparam int C_RUN    = 0;
	localparam int C_CLR_LO = 1;
	localparam int C_CLR_HI = 2;
	localparam int C_CAPA   = 3;
	localparam int C_CAPB   = 4;
	localparam int C_IE_LO  = 5;
	localparam int C_IE_HI  = 7;
	localparam int CTRL_W   = 8;
	localparam logic [1:0] CLR_A = 2'h1;
	localparam logic [1:0] CLR_B = 2'h2;
	// status flag positions
	localparam int F_A = 0;
	localparam int F_B = 1;
	localparam int F_W = 2;
	// mode fields; buffer enable of channel 3+j, register r at M_BUF_LO+2*j+r
	localparam int M_PHASE  = 0;
	localparam int M_RSPWM  = 1;
	localparam int M_CMPWM  = 2;
	localparam int M_BUF_LO = 3;
	localparam int MODE_W   = 7;
	// output control fields
	localparam int O_LEVEL_SELECT_CH3   = 0;
	localparam int O_LEVEL_SELECT_CH4   = 1;
	localparam int O_EXT_TRIGGER_DISABLE   = 2;
	localparam int OUTCTL_W = 3;
	localparam logic [OUTCTL_W-1:0] OUTCTL_RST = 3'h7;
	localparam logic [NOUT-1:0]     OUTEN_RST  = 6'h00;
	// synchroniser lanes
	localparam int Q_A     = 0;
	localparam int Q_B     = 1;
	localparam int CAPA_LO = 2;
	localparam int CAPB_LO = 7;
	localparam int NSYNC   = 12;
	localparam logic [CW-1:0] CNT_MAX  = 16'hffff;
	localparam logic [CW-1:0] CNT_ZERO = 16'h0000;
	typedef enum logic [1:0] {CM_UP = 2'b01, CM_DOWN = 2'b10} mtb_dir_t;
endpackage

/* File: rtl/mtb_ch_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface mtb_ch_if;
	logic [mtb_pkg::CTRL_W-1:0] ctrl;
	logic [mtb_pkg::NFL-1:0]    flags;
	logic [mtb_pkg::NFL-1:0]    flag_en;
	logic [mtb_pkg::CW-1:0]     count;
	logic [mtb_pkg::CW-1:0]     gra;
	logic [mtb_pkg::CW-1:0]     grb;
	logic [mtb_pkg::CW-1:0]     xval_a;
	logic [mtb_pkg::CW-1:0]     xval_b;
	logic [mtb_pkg::CW-1:0]     wdata;
	logic [2:0]                 wr;
	logic                       wr_en;
	logic                       rd_stat;
	logic                       step;
	logic                       down;
	logic                       clr_ext;
	logic                       cap_a;
	logic                       cap_b;
	logic                       xfer_a;
	logic                       xfer_b;
	logic                       match_a;
	logic                       match_b;
	logic                       wrap;
	logic                       capev_a;
	logic                       capev_b;
	modport ctl (output step, down, clr_ext, cap_a, cap_b, xfer_a, xfer_b, xval_a, xval_b,
		flag_en, wr_en, wr, rd_stat, wdata,
		input ctrl, flags, count, gra, grb, match_a, match_b, wrap, capev_a, capev_b);
	modport chan (input step, down, clr_ext, cap_a, cap_b, xfer_a, xfer_b, xval_a, xval_b,
		flag_en, wr_en, wr, rd_stat, wdata,
		output ctrl, flags, count, gra, grb, match_a, match_b, wrap, capev_a, capev_b);
endinterface
`default_nettype wire

/* File: rtl/mtb_chan.sv */
`timescale 1ns/10ps
`default_nettype none
module mtb_chan (
	input  wire logic clk_sys_i,
	input  wire logic resetn_i,
	mtb_ch_if.chan    bus
);
	logic [mtb_pkg::CTRL_W-1:0] ctrl;
	logic [mtb_pkg::CW-1:0]     count;
	logic [mtb_pkg::CW-1:0]     gra;
	logic [mtb_pkg::CW-1:0]     grb;
	logic [mtb_pkg::NFL-1:0]    flags;
	logic [mtb_pkg::NFL-1:0]    armed;
	logic [mtb_pkg::NFL-1:0]    set_ev;
	logic [mtb_pkg::NFL-1:0]    clr_ev;
	logic [1:0]                 clr_sel;
	logic                       do_clr;
	logic                       wr_stat;

	// events: capture only in capture use, match in the advancing cycle
	assign bus.capev_a = bus.cap_a & ctrl[mtb_pkg::C_CAPA];
	assign bus.capev_b = bus.cap_b & ctrl[mtb_pkg::C_CAPB];
	assign bus.match_a = bus.step & ~ctrl[mtb_pkg::C_CAPA] & (count == gra);
	assign bus.match_b = bus.step & ~ctrl[mtb_pkg::C_CAPB] & (count == grb);
	assign bus.wrap    = bus.step & (bus.down ? (count == mtb_pkg::CNT_ZERO)
		: (count == mtb_pkg::CNT_MAX));
	assign clr_sel     = ctrl[mtb_pkg::C_CLR_HI:mtb_pkg::C_CLR_LO];
	assign do_clr      = bus.clr_ext
		| ((clr_sel == mtb_pkg::CLR_A) & (bus.match_a | bus.capev_a))
		| ((clr_sel == mtb_pkg::CLR_B) & (bus.match_b | bus.capev_b));
	assign wr_stat     = bus.wr_en & (bus.wr == mtb_pkg::R_STAT);

	// control register
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			ctrl <= '0;
		else if (bus.wr_en && bus.wr == mtb_pkg::R_CTRL)
			ctrl <= bus.wdata[mtb_pkg::CTRL_W-1:0];
	end

	// counter: clear beats a write, a write beats a step
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			count <= mtb_pkg::CNT_ZERO;
		else if (do_clr)
			count <= mtb_pkg::CNT_ZERO;
		else if (bus.wr_en && bus.wr == mtb_pkg::R_CNT)
			count <= bus.wdata;
		else if (bus.step)
			count <= bus.down ? count - 1'b1 : count + 1'b1;
	end

	// register a: capture first, then software, then buffer transfer
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			gra <= mtb_pkg::CNT_MAX;
		else if (bus.capev_a)
			gra <= count;
		else if (bus.wr_en && bus.wr == mtb_pkg::R_GRA)
			gra <= bus.wdata;
		else if (bus.xfer_a)
			gra <= bus.xval_a;
	end

	// register b, same order
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			grb <= mtb_pkg::CNT_MAX;
		else if (bus.capev_b)
			grb <= count;
		else if (bus.wr_en && bus.wr == mtb_pkg::R_GRB)
			grb <= bus.wdata;
		else if (bus.xfer_b)
			grb <= bus.xval_b;
	end

	// flags: cleared by a zero write only after a read that saw one
	assign set_ev = bus.flag_en & {bus.wrap, bus.match_b | bus.capev_b,
		bus.match_a | bus.capev_a};
	assign clr_ev = {mtb_pkg::NFL{wr_stat}} & armed & ~bus.wdata[mtb_pkg::NFL-1:0];
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			flags <= '0;
			armed <= '0;
		end else begin
			flags <= set_ev | (flags & ~clr_ev);
			if (bus.rd_stat)
				armed <= flags;
			else if (wr_stat)
				armed <= '0;
		end
	end

	assign bus.ctrl  = ctrl;
	assign bus.count = count;
	assign bus.gra   = gra;
	assign bus.grb   = grb;
	assign bus.flags = flags;
endmodule
`default_nettype wire

/* File: rtl/mtb_timer.sv */
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module mtb_timer (
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] pwdata_i,
	output logic      [31:0] prdata_o,
	output logic             pready_o,
	output logic             pslverr_o,
	input  wire logic        quad_input_a_i,
	input  wire logic        quad_input_b_i,
	input  wire logic [4:0]  capture_a_i,
	input  wire logic [4:0]  capture_b_i,
	input  wire logic [5:0]  port_data_i,
	input  wire logic [5:0]  port_dir_i,
	output logic      [5:0]  pin_o,
	output logic      [5:0]  pin_oe_o,
	output logic      [14:0] irq_o
);
	localparam int NB = mtb_pkg::NCH - mtb_pkg::CH_BUF0;

	logic [mtb_pkg::NSYNC-1:0]    sync1;
	logic [mtb_pkg::NSYNC-1:0]    sync2;
	logic [mtb_pkg::NSYNC-1:0]    prev;
	logic                         a_ch;
	logic                         b_ch;
	logic                         quad_step;
	logic                         quad_down;
	logic [mtb_pkg::NCH-1:0]      cap_a_ev;
	logic [mtb_pkg::NCH-1:0]      cap_b_ev;
	logic [mtb_pkg::CTRL_W-1:0]   ctrl_v [mtb_pkg::NCH];
	logic [mtb_pkg::NFL-1:0]      flag_v [mtb_pkg::NCH];
	logic [mtb_pkg::NFL-1:0]      fen_v  [mtb_pkg::NCH];
	logic [mtb_pkg::CW-1:0]       cnt_v  [mtb_pkg::NCH];
	logic [mtb_pkg::CW-1:0]       gra_v  [mtb_pkg::NCH];
	logic [mtb_pkg::CW-1:0]       grb_v  [mtb_pkg::NCH];
	logic [mtb_pkg::CW-1:0]       buffer_a    [NB];
	logic [mtb_pkg::CW-1:0]       brb    [NB];
	logic [mtb_pkg::NCH-1:0]      step;
	logic [mtb_pkg::NCH-1:0]      down;
	logic [mtb_pkg::NCH-1:0]      clr_ext;
	logic [mtb_pkg::NCH-1:0]      mat_a;
	logic [mtb_pkg::NCH-1:0]      mat_b;
	logic [mtb_pkg::NCH-1:0]      wrap;
	logic [mtb_pkg::NCH-1:0]      cev_a;
	logic [mtb_pkg::NCH-1:0]      cev_b;
	logic [mtb_pkg::NCH-1:0]      xf_a;
	logic [mtb_pkg::NCH-1:0]      xf_b;
	logic [mtb_pkg::MODE_W-1:0]   mode;
	logic [mtb_pkg::OUTCTL_W-1:0] outctl;
	logic [mtb_pkg::NOUT-1:0]     outen;
	logic [mtb_pkg::NOUT-1:0]     tog;
	logic [mtb_pkg::NOUT-1:0]     tout;
	mtb_pkg::mtb_dir_t            cm_dir;
	logic                         phase;
	logic                         rspwm;
	logic                         cmpwm;
	logic                         cm_dn;
	logic                         rev_top;
	logic                         rev_bot;
	logic                         trip;
	logic [2:0]                   ch_sel;
	logic [2:0]                   idx;
	logic                         ch_hit;
	logic                         buf_ch;
	logic                         reg_ok;
	logic                         glob_ok;
	logic                         bad;
	logic                         acc;
	logic                         wr_ok;
	logic                         rd_setup;
	logic                         bsel;
	logic [31:0]                  rd;

	// ****************************************
	// pin synchronisers and edge detection
	// ****************************************

	// two flops per pin, then one more stage for edges
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			sync1 <= '0;
			sync2 <= '0;
			prev  <= '0;
		end else begin
			sync1 <= {capture_b_i, capture_a_i, quad_input_b_i, quad_input_a_i};
			sync2 <= sync1;
			prev  <= sync2;
		end
	end

	// rising edges of capture pins
	assign cap_a_ev = sync2[mtb_pkg::CAPA_LO +: mtb_pkg::NCH]
		& ~prev[mtb_pkg::CAPA_LO +: mtb_pkg::NCH];
	assign cap_b_ev = sync2[mtb_pkg::CAPB_LO +: mtb_pkg::NCH]
		& ~prev[mtb_pkg::CAPB_LO +: mtb_pkg::NCH];

	// quadrature: any single edge steps, phase relation sets direction
	assign a_ch      = sync2[mtb_pkg::Q_A] ^ prev[mtb_pkg::Q_A];
	assign b_ch      = sync2[mtb_pkg::Q_B] ^ prev[mtb_pkg::Q_B];
	assign quad_step = a_ch ^ b_ch;
	assign quad_down = a_ch ^ (sync2[mtb_pkg::Q_A] ^ sync2[mtb_pkg::Q_B]);

	// ****************************************
	// mode decode and channel steering
	// ****************************************

	assign phase = mode[mtb_pkg::M_PHASE];
	assign rspwm = mode[mtb_pkg::M_RSPWM];
	assign cmpwm = mode[mtb_pkg::M_CMPWM];
	assign cm_dn = (cm_dir == mtb_pkg::CM_DOWN);

	// count enables, direction, forced clears and flag masks per channel
	always_comb begin
		for (int g = 0; g < mtb_pkg::NCH; g++) begin
			step[g]    = ctrl_v[g][mtb_pkg::C_RUN];
			down[g]    = 1'b0;
			clr_ext[g] = 1'b0;
			fen_v[g]   = '1;
		end
		if (phase) begin
			// the pin edges gate the run-bit step on channel 2 only
			step[2] = ctrl_v[2][mtb_pkg::C_RUN] & quad_step;
			down[2] = quad_down;
		end
		if (cmpwm) begin
			down[3]                = cm_dn;
			down[4]                = cm_dn;
			fen_v[3][mtb_pkg::F_A] = ~cm_dn;
			fen_v[4][mtb_pkg::F_W] = cm_dn;
		end
		if (rspwm)
			clr_ext[3] = mat_a[3];
	end

	// direction reversals of the complementary pair
	assign rev_top = cmpwm & ~cm_dn & mat_a[3];
	assign rev_bot = cmpwm & cm_dn & wrap[4];

	// up/down state of the complementary pair, starts up from the preset counts
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			cm_dir <= mtb_pkg::CM_UP;
		else if (!cmpwm)
			cm_dir <= mtb_pkg::CM_UP;
		else begin
			case (cm_dir)
				mtb_pkg::CM_UP: begin
					if (rev_top)
						cm_dir <= mtb_pkg::CM_DOWN;
				end
				mtb_pkg::CM_DOWN: begin
					if (rev_bot)
						cm_dir <= mtb_pkg::CM_UP;
				end
				default: cm_dir <= mtb_pkg::CM_UP;
			endcase
		end
	end

	// ****************************************
	// buffer transfer and capture buffering
	// ****************************************

	// transfer moments depend on mode; only channels 3 and 4 have buffers
	always_comb begin
		xf_a = '0;
		xf_b = '0;
		for (int j = 0; j < NB; j++) begin
			if (cmpwm) begin
				xf_a[j + mtb_pkg::CH_BUF0] = rev_top | rev_bot;
				xf_b[j + mtb_pkg::CH_BUF0] = rev_top | rev_bot;
			end else if (rspwm) begin
				xf_a[j + mtb_pkg::CH_BUF0] = mat_a[3];
				xf_b[j + mtb_pkg::CH_BUF0] = mat_a[3];
			end else begin
				xf_a[j + mtb_pkg::CH_BUF0] = mat_a[j + mtb_pkg::CH_BUF0];
				xf_b[j + mtb_pkg::CH_BUF0] = mat_b[j + mtb_pkg::CH_BUF0];
			end
			xf_a[j + mtb_pkg::CH_BUF0] &= mode[mtb_pkg::M_BUF_LO + 2 * j];
			xf_b[j + mtb_pkg::CH_BUF0] &= mode[mtb_pkg::M_BUF_LO + 2 * j + 1];
		end
	end

	// buffers: a capture pushes the old register value, else software writes
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			for (int j = 0; j < NB; j++) begin
				buffer_a[j] <= mtb_pkg::CNT_MAX;
				brb[j] <= mtb_pkg::CNT_MAX;
			end
		end else begin
			for (int j = 0; j < NB; j++) begin
				if (mode[mtb_pkg::M_BUF_LO + 2 * j] && cev_a[j + mtb_pkg::CH_BUF0])
					buffer_a[j] <= gra_v[j + mtb_pkg::CH_BUF0];
				else if (wr_ok && reg_ok && idx == mtb_pkg::R_BRA && bsel == j[0])
					buffer_a[j] <= pwdata_i[mtb_pkg::CW-1:0];
				if (mode[mtb_pkg::M_BUF_LO + 2 * j + 1] && cev_b[j + mtb_pkg::CH_BUF0])
					brb[j] <= grb_v[j + mtb_pkg::CH_BUF0];
				else if (wr_ok && reg_ok && idx == mtb_pkg::R_BRB && bsel == j[0])
					brb[j] <= pwdata_i[mtb_pkg::CW-1:0];
			end
		end
	end

	// ****************************************
	// channel instances
	// ****************************************

	for (genvar g = 0; g < mtb_pkg::NCH; g++) begin : g_ch
		mtb_ch_if chif ();

		mtb_chan u_chan (
			.clk_sys_i (clk_sys_i),
			.resetn_i  (resetn_i),
			.bus       (chif)
		);

		// steering into the channel
		assign chif.step    = step[g];
		assign chif.down    = down[g];
		assign chif.clr_ext = clr_ext[g];
		assign chif.flag_en = fen_v[g];
		assign chif.cap_a   = cap_a_ev[g];
		assign chif.cap_b   = cap_b_ev[g];
		assign chif.xfer_a  = xf_a[g];
		assign chif.xfer_b  = xf_b[g];
		assign chif.wdata   = pwdata_i[mtb_pkg::CW-1:0];
		assign chif.wr      = idx;
		assign chif.wr_en   = wr_ok & reg_ok & (ch_sel == 3'(g)) & (idx <= mtb_pkg::R_GRB);
		assign chif.rd_stat = rd_setup & (ch_sel == 3'(g)) & (idx == mtb_pkg::R_STAT);
		if (g >= mtb_pkg::CH_BUF0) begin : g_buf
			assign chif.xval_a = buffer_a[g - mtb_pkg::CH_BUF0];
			assign chif.xval_b = brb[g - mtb_pkg::CH_BUF0];
		end else begin : g_nobuf
			assign chif.xval_a = '0;
			assign chif.xval_b = '0;
		end

		// state gathered back from the channel
		assign ctrl_v[g] = chif.ctrl;
		assign flag_v[g] = chif.flags;
		assign cnt_v[g]  = chif.count;
		assign gra_v[g]  = chif.gra;
		assign grb_v[g]  = chif.grb;
		assign mat_a[g]  = chif.match_a;
		assign mat_b[g]  = chif.match_b;
		assign wrap[g]   = chif.wrap;
		assign cev_a[g]  = chif.capev_a;
		assign cev_b[g]  = chif.capev_b;

		// one request per flag, each gated by its own enable bit, with no ranking between them
		assign irq_o[g * mtb_pkg::NFL +: mtb_pkg::NFL] =
			flag_v[g] & ctrl_v[g][mtb_pkg::C_IE_HI:mtb_pkg::C_IE_LO];
	end

	// ****************************************
	// output waveforms and pin gating
	// ****************************************

	// normal-mode toggles on compare matches of channels 3 and 4
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			tog <= '0;
		else
			tog <= tog ^ {1'b0, mat_b[4], 1'b0, mat_a[4], mat_b[3], mat_a[3]};
	end

	// pwm pairs: set at clear/reset at match, or non-overlapped pair
	always_comb begin
		logic [mtb_pkg::CW-1:0] cv;
		logic                   pos;
		logic                   neg;
		logic                   ols;
		cv   = '0;
		pos  = 1'b0;
		neg  = 1'b0;
		ols  = 1'b0;
		tout = tog;
		if (rspwm || cmpwm) begin
			for (int k = 0; k < 3; k++) begin
				cv  = (k == 0) ? grb_v[3] : (k == 1) ? gra_v[4] : grb_v[4];
				ols = (k == 0) ? outctl[mtb_pkg::O_LEVEL_SELECT_CH3] : outctl[mtb_pkg::O_LEVEL_SELECT_CH4];
				if (rspwm) begin
					pos = cnt_v[3] < cv;
					neg = ~pos;
				end else begin
					pos = cnt_v[4] >= cv;
					neg = cnt_v[3] < cv;
				end
				tout[2 * k]     = pos ^ ~ols;
				tout[2 * k + 1] = neg ^ ~ols;
			end
		end
	end

	// disabled outputs hand the pin back to the port settings
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			pin_o    <= '0;
			pin_oe_o <= '0;
		end else begin
			pin_o    <= (outen & tout) | (~outen & port_data_i);
			pin_oe_o <= outen | port_dir_i;
		end
	end

	// ****************************************
	// apb slave
	// ****************************************

	assign ch_sel   = paddr_i[7:5];
	assign idx      = paddr_i[4:2];
	assign bsel     = paddr_i[7];
	assign ch_hit   = ch_sel <= mtb_pkg::CH_LAST;
	assign buf_ch   = (ch_sel == 3'(mtb_pkg::CH_BUF0)) | (ch_sel == mtb_pkg::CH_LAST);
	assign reg_ok   = ch_hit & ((idx <= mtb_pkg::R_GRB) | (buf_ch & (idx <= mtb_pkg::R_BRB)));
	assign glob_ok  = (paddr_i == mtb_pkg::A_MODE) | (paddr_i == mtb_pkg::A_OUTEN)
		| (paddr_i == mtb_pkg::A_OUTCTL);
	assign bad      = ~(reg_ok | glob_ok) | (paddr_i[1:0] != 2'h0);
	assign acc      = psel_i & penable_i;
	assign wr_ok    = acc & pwrite_i & ~bad;
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i & ~bad;
	assign pready_o  = 1'b1;
	assign pslverr_o = acc & bad;

	// read data, zero for unmapped addresses and unused bits
	always_comb begin
		rd = '0;
		if (reg_ok) begin
			case (idx)
				mtb_pkg::R_CTRL: rd[mtb_pkg::CTRL_W-1:0] = ctrl_v[ch_sel];
				mtb_pkg::R_STAT: rd[mtb_pkg::NFL-1:0]    = flag_v[ch_sel];
				mtb_pkg::R_CNT:  rd[mtb_pkg::CW-1:0]     = cnt_v[ch_sel];
				mtb_pkg::R_GRA:  rd[mtb_pkg::CW-1:0]     = gra_v[ch_sel];
				mtb_pkg::R_GRB:  rd[mtb_pkg::CW-1:0]     = grb_v[ch_sel];
				mtb_pkg::R_BRA:  rd[mtb_pkg::CW-1:0]     = buffer_a[bsel];
				mtb_pkg::R_BRB:  rd[mtb_pkg::CW-1:0]     = brb[bsel];
				default:         rd = '0;
			endcase
		end else if (paddr_i == mtb_pkg::A_MODE)
			rd[mtb_pkg::MODE_W-1:0] = mode;
		else if (paddr_i == mtb_pkg::A_OUTEN)
			rd[mtb_pkg::NOUT-1:0] = outen;
		else if (paddr_i == mtb_pkg::A_OUTCTL)
			rd[mtb_pkg::OUTCTL_W-1:0] = outctl;
	end

	// read data is taken in the setup cycle and held through the access;
	// a refused read (misaligned too) returns zero
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			prdata_o <= '0;
		else if (psel_i && !penable_i)
			prdata_o <= bad ? '0 : rd;
	end

	// mode and level control
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i) begin
			mode   <= '0;
			outctl <= mtb_pkg::OUTCTL_RST;
		end else begin
			if (wr_ok && paddr_i == mtb_pkg::A_MODE)
				mode <= pwdata_i[mtb_pkg::MODE_W-1:0];
			if (wr_ok && paddr_i == mtb_pkg::A_OUTCTL)
				outctl <= pwdata_i[mtb_pkg::OUTCTL_W-1:0];
		end
	end

	// output enables; a channel 1 capture A trips them in pwm modes
	assign trip = (rspwm | cmpwm) & ~outctl[mtb_pkg::O_EXT_TRIGGER_DISABLE] & cev_a[1];
	always_ff @(posedge clk_sys_i or negedge resetn_i) begin
		if (!resetn_i)
			outen <= mtb_pkg::OUTEN_RST;
		else if (trip)
			outen <= '0;
		else if (wr_ok && paddr_i == mtb_pkg::A_OUTEN)
			outen <= pwdata_i[mtb_pkg::NOUT-1:0];
	end
endmodule
`default_nettype wire

/* File: testbench/mtb_timer_sva.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// port checks of the timer block
// ************************************************************
module mtb_timer_sva (
	input  wire logic        clk_sys_i,
	input  wire logic        resetn_i,
	input  wire logic        psel_i,
	input  wire logic        penable_i,
	input  wire logic        pwrite_i,
	input  wire logic [7:0]  paddr_i,
	input  wire logic [31:0] prdata_o,
	input  wire logic        pready_o,
	input  wire logic        pslverr_o,
	input  wire logic [5:0]  port_dir_i,
	input  wire logic [5:0]  pin_oe_o,
	input  wire logic [14:0] irq_o
);
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!resetn_i);
	logic acc;
	// access phase of a transfer
	assign acc = psel_i && penable_i;
	chk_buf_absent: assert property (
		acc && paddr_i inside {8'h14, 8'h18, 8'h34, 8'h38, 8'h54, 8'h58} |-> pslverr_o)
		else $error("buffer slot answered below channel 3");
	chk_buf_present: assert property (
		acc && paddr_i inside {8'h74, 8'h78, 8'h94, 8'h98} |-> !pslverr_o)
		else $error("buffer slot refused on channel 3 or 4");
	chk_err_phase: assert property (pslverr_o |-> acc)
		else $error("error outside access phase");
	chk_err_align: assert property (acc && paddr_i[1:0] != 2'h0 |-> pslverr_o)
		else $error("misaligned access accepted");
	chk_ready_high: assert property (pready_o)
		else $error("ready low");
	chk_rdata_hold: assert property (acc |=> $stable(prdata_o))
		else $error("read data moved after access");
	chk_err_zero: assert property (acc && !pwrite_i && pslverr_o |-> prdata_o == 32'h0)
		else $error("refused read returned data");
	chk_dir_drives: assert property (
		$past(resetn_i) |-> (pin_oe_o & $past(port_dir_i)) == $past(port_dir_i))
		else $error("port direction not driving pin");
	chk_irq_idle: assert property ($rose(resetn_i) |-> irq_o == 15'h0000)
		else $error("request raised out of reset");
	// main scenarios
	cover property (acc && pwrite_i);
	cover property (acc && pslverr_o);
	cover property (irq_o != 15'h0000);
endmodule
bind mtb_timer mtb_timer_sva mtb_timer_sva_i (.*);
`default_nettype wire

/* File: testbench/mtb_enc_model.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// two-phase encoder driving the quadrature pins
// ************************************************************
module mtb_enc_model (
	input  wire logic clk_sys_i,
	input  wire logic run_i,
	input  wire logic down_i,
	output logic      quad_input_a_o,
	output logic      quad_input_b_o,
	output int        steps_o
);
	logic [1:0] ph = 2'h0;
	logic [1:0] div = 2'h0;
	int         n = 0;
	// one edge every four clocks keeps width, spacing and overlap margins
	always_ff @(posedge clk_sys_i) begin
		div <= div + 2'h1;
		if (run_i && div == 2'h3) begin
			ph <= down_i ? ph - 2'h1 : ph + 2'h1;
			n <= down_i ? n - 1 : n + 1;
		end
	end
	// gray order: a leads b when stepping up
	assign quad_input_a_o = ph[0] ^ ph[1];
	assign quad_input_b_o = ph[1];
	assign steps_o = n;
endmodule
`default_nettype wire

/* File: testbench/mtb_timer_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
// ************************************************************
// bench top: clock, reset, bus tasks and scenarios
// ************************************************************
module mtb_timer_tb_top;
	logic        clk_sys_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        psel_i = 1'b0;
	logic        penable_i = 1'b0;
	logic        pwrite_i = 1'b0;
	logic [7:0]  paddr_i = 8'h00;
	logic [31:0] pwdata_i = 32'h0;
	logic [31:0] prdata_o;
	logic        pready_o;
	logic        pslverr_o;
	logic        quad_input_a_i;
	logic        quad_input_b_i;
	logic [4:0]  capture_a_i = 5'h00;
	logic [4:0]  capture_b_i = 5'h00;
	logic [5:0]  port_data_i = 6'h00;
	logic [5:0]  port_dir_i = 6'h00;
	logic [5:0]  pin_o;
	logic [5:0]  pin_oe_o;
	logic [14:0] irq_o;
	logic        enc_run = 1'b0;
	logic        enc_down = 1'b0;
	int          enc_steps;
	int          fails = 0;
	int          samples_checked = 0;
	logic [31:0] rd;
	mtb_timer mtb_timer_i (.*);
	mtb_enc_model mtb_enc_model_i (.clk_sys_i(clk_sys_i), .run_i(enc_run), .down_i(enc_down),
		.quad_input_a_o(quad_input_a_i), .quad_input_b_o(quad_input_b_i), .steps_o(enc_steps));
	// 50 ns clock
	initial begin
		forever #25 clk_sys_i = ~clk_sys_i;
	end
	// one bus transfer, held until ready is seen, then one idle cycle
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_sys_i);
		penable_i <= 1'b1;
		@(posedge clk_sys_i);
		while (pready_o !== 1'b1) @(posedge clk_sys_i);
		rd = prdata_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_sys_i);
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		samples_checked++;
		if (g !== e) begin
			fails++;
			$display("MISMATCH t=%0t got %h exp %h", $time, g, e);
		end
	endtask
	task rdchk(input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task finish_test;
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// reset values, buffer slots and wrap on channel 0
	task test_reset;
		rdchk(8'h6c, 32'hffff);
		rdchk(8'ha8, 32'h7);
		rdchk(8'h14, 32'h0);
		apb(1'b1, 8'h08, 32'hfffe);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h00, 32'h0);
		rdchk(8'h04, 32'h7);
	endtask
	// encoder up then down on channel 2
	task test_quad;
		apb(1'b1, 8'ha0, 32'h1);
		apb(1'b1, 8'h40, 32'h1);
		for (int d = 0; d < 2; d++) begin
			enc_down <= d[0];
			enc_run <= 1'b1;
			repeat (40 - 12 * d) @(posedge clk_sys_i);
			enc_run <= 1'b0;
			repeat (6) @(posedge clk_sys_i);
			rdchk(8'h48, 32'(enc_steps));
		end
		apb(1'b1, 8'h40, 32'h0);
	endtask
	// compare buffer, flag clearing and request on channel 3
	task test_match_buf;
		apb(1'b1, 8'ha0, 32'h8);
		apb(1'b1, 8'h6c, 32'h5);
		apb(1'b1, 8'h74, 32'h9);
		apb(1'b1, 8'h60, 32'h21);
		repeat (20) @(posedge clk_sys_i);
		apb(1'b1, 8'h60, 32'h20);
		rdchk(8'h6c, 32'h9);
		chk({17'h0, irq_o}, 32'h200);
		apb(1'b1, 8'h64, 32'h0);
		rdchk(8'h64, 32'h1);
		apb(1'b1, 8'h64, 32'h0);
		rdchk(8'h64, 32'h0);
		chk({17'h0, irq_o}, 32'h0);
	endtask
	// capture into buffered register of channel 4
	task test_capture;
		apb(1'b1, 8'ha0, 32'h20);
		apb(1'b1, 8'h8c, 32'h1234);
		apb(1'b1, 8'h80, 32'h9);
		capture_a_i <= 5'h10;
		repeat (6) @(posedge clk_sys_i);
		capture_a_i <= 5'h00;
		apb(1'b1, 8'h80, 32'h0);
		rdchk(8'h94, 32'h1234);
		rdchk(8'h8c, 32'h3);
		rdchk(8'h84, 32'h1);
	endtask
	// complementary pair: buffered duty moves only at the reversals
	task test_cmpwm;
		apb(1'b1, 8'ha0, 32'h14);
		apb(1'b1, 8'h6c, 32'h40);
		apb(1'b1, 8'h70, 32'h5);
		apb(1'b1, 8'h78, 32'h6);
		// count 3 starts three cycles after count 4: margin 2 plus 3
		apb(1'b1, 8'h68, 32'h5);
		apb(1'b1, 8'h88, 32'h0);
		apb(1'b1, 8'h80, 32'h1);
		apb(1'b1, 8'h60, 32'h1);
		rdchk(8'h70, 32'h5);
		repeat (140) @(posedge clk_sys_i);
		rdchk(8'h70, 32'h6);
		rdchk(8'h84, 32'h7);
		apb(1'b1, 8'h60, 32'h0);
		apb(1'b1, 8'h80, 32'h0);
		apb(1'b1, 8'ha0, 32'h0);
	endtask
	// port fallback and external trip of the outputs
	task test_outputs;
		port_dir_i <= 6'h3f;
		port_data_i <= 6'h2a;
		repeat (3) @(posedge clk_sys_i);
		chk({26'h0, pin_o}, 32'h2a);
		apb(1'b1, 8'ha0, 32'h12);
		apb(1'b1, 8'ha8, 32'h1);
		apb(1'b1, 8'h20, 32'h8);
		apb(1'b1, 8'h68, 32'h0);
		apb(1'b1, 8'ha4, 32'h3f);
		rdchk(8'ha4, 32'h3f);
		// count 0 below all compares; pair 3 kept, pairs of 4 inverted
		chk({26'h0, pin_o}, 32'h29);
		capture_a_i <= 5'h02;
		repeat (6) @(posedge clk_sys_i);
		capture_a_i <= 5'h00;
		rdchk(8'ha4, 32'h0);
		chk({26'h0, pin_o}, 32'h2a);
		// buffered duty moves at the period match, not at its own match
		apb(1'b1, 8'h78, 32'h7);
		apb(1'b1, 8'h60, 32'h1);
		repeat (20) @(posedge clk_sys_i);
		rdchk(8'h70, 32'h6);
		repeat (60) @(posedge clk_sys_i);
		rdchk(8'h70, 32'h7);
		apb(1'b1, 8'h60, 32'h0);
	endtask
	// main sequence
	initial begin
		repeat (8) @(posedge clk_sys_i);
		resetn_i <= 1'b1;
		test_reset;
		test_quad;
		test_match_buf;
		test_capture;
		test_cmpwm;
		test_outputs;
		finish_test;
	end
	// hang guard, well past the expected run length
	initial begin
		repeat (5000) @(posedge clk_sys_i);
		fails++;
		finish_test;
	end
endmodule
`default_nettype wire
